// *** hdl/mrmc_pkg.sv ***
// Function
// - Ten byte-wide registers, seven write-only, three read-only, on the processor bus.
// - Write-only registers configure the modem; read-only registers report its status.
// - All four address lines select a register on every access.
// - Address bit 3 low selects the self-running modem register set.
// - Address bit 3 high selects the processor-timed transceiver register set.
// - Address 7 holds nothing; valid addresses are 0-6 and 8-A.
// - A bit is asserted when one and negated when zero.
// - Carrier detect asserts 40 to 205 ms after valid carrier appears.
// - Carrier detect releases in 17+-7 ms for FSK/PSK, 40-65 ms for QAM.
// - Voice-jack setting lowers every transmit level by 5.5 dB.
// - The 1800 Hz guard tone is added only in high-band transmission.
// - Receive uses high-band filter when originating, low-band when answering.
// - Self test loops transmit back to receive through the 3600 Hz mixer.
package mrmc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int unsigned TICK_W = 16;
    localparam int unsigned CD_ACQ_MIN_MS = 40;
    localparam int unsigned CD_REL_PSK_MS = 17;
    localparam int unsigned CD_REL_QAM_MIN_MS = 40;
    // One extra tick covers the unknown phase of the first tick
    localparam logic [7:0] CD_ACQ_TICKS = 8'(CD_ACQ_MIN_MS + 1);
    localparam logic [7:0] CD_REL_PSK_TICKS = 8'(CD_REL_PSK_MS);
    localparam logic [7:0] CD_REL_QAM_TICKS = 8'(CD_REL_QAM_MIN_MS + 1);
    // ----------------------------------------
    // Addresses
    // ----------------------------------------
    localparam logic [3:0] ADDR_LINE_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CUST_CTRL = 4'h1;
    localparam logic [3:0] ADDR_MODEM_STAT = 4'h2;
    localparam logic [3:0] ADDR_RELAY_STAT = 4'h3;
    localparam logic [3:0] ADDR_ASYNC_OPT = 4'h4;
    localparam logic [3:0] ADDR_INTL_OPT = 4'h5;
    localparam logic [3:0] ADDR_CLAMP_TEST = 4'h6;
    localparam logic [3:0] ADDR_UNUSED = 4'h7;
    localparam logic [3:0] ADDR_XCVR_CTRL1 = 4'h8;
    localparam logic [3:0] ADDR_XCVR_CTRL2 = 4'h9;
    localparam logic [3:0] ADDR_XCVR_STAT = 4'hA;
    localparam int unsigned BANK_BIT = 3;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int unsigned CC_VOICE_BIT = 5;
    localparam int unsigned CC_ORIG_BIT = 4;
    localparam int unsigned CC_ALOOP_BIT = 2;
    localparam int unsigned IDO_GUARD_BIT = 5;
    localparam int unsigned TC1_ORIG_BIT = 3;
    localparam int unsigned TC1_GUARD_BIT = 0;
    localparam int unsigned RLS_CARRIER_BIT = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] PINS_IDLE = 16'hE000;

    typedef struct packed {
        logic [7:0] line_and_phone_control;
        logic [7:0] customer_control;
        logic [7:0] async_handshake_options;
        logic [7:0] intl_disconnect_options;
        logic [7:0] data_clamp_and_test;
        logic [7:0] transceiver_control_one;
        logic [7:0] transceiver_control_two;
    } mrmc_regs_type;

    typedef struct packed {
        logic [7:0] modem_status;
        logic [7:0] relay_lamp_status;
        logic [7:0] transceiver_status;
    } mrmc_stat_type;

    typedef struct packed {
        logic voice_jack;
        logic tx_high_band;
        logic rx_high_band;
        logic guard_tone;
        logic loop_mixer;
    } mrmc_analog_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] addr;
        logic [7:0] data;
        logic energy;
    } mrmc_pins_type;
endpackage

// *** hdl/mrmc_sync3.sv ***
`timescale 1ns/1ns
module mrmc_sync3 #(
    parameter int unsigned W = 16,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw and settled inputs
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } mrmc_sync_state_type;

    mrmc_sync_state_type st;
    mrmc_sync_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A bit changes once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= {IDLE, IDLE, IDLE, IDLE};
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule // mrmc_sync3

// *** hdl/mrmc_cd_timer.sv ***
`timescale 1ns/1ns
module mrmc_cd_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Millisecond tick and line state
    input wire logic tick,
    input wire logic energy,
    input wire logic qam,
    // Carrier detected
    output logic detect
);
    typedef struct packed {
        logic detect;
        logic [7:0] cnt;
    } mrmc_cd_state_type;

    mrmc_cd_state_type st;
    mrmc_cd_state_type next_st;
    logic [7:0] target;

    always_comb begin
        next_st = st;
        target = mrmc_pkg::CD_ACQ_TICKS;
        if (st.detect) begin
            target = qam ? mrmc_pkg::CD_REL_QAM_TICKS : mrmc_pkg::CD_REL_PSK_TICKS;
        end
        if (energy == st.detect) begin
            next_st.cnt = 8'h00;
        end else if (tick) begin
            if (st.cnt + 8'h01 >= target) begin
                next_st.detect = energy;
                next_st.cnt = 8'h00;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign detect = st.detect;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_acq_counted: assert property ($rose(detect) |-> $past(tick) && $past(energy)
        && $past(st.cnt) == mrmc_pkg::CD_ACQ_TICKS - 8'h01) else $error("carrier acquired early");
    a_rel_counted: assert property ($fell(detect) |-> $past(tick) && !$past(energy)
        && $past(st.cnt) == ($past(qam) ? mrmc_pkg::CD_REL_QAM_TICKS : mrmc_pkg::CD_REL_PSK_TICKS) - 8'h01)
        else $error("carrier released off count");
    c_carrier_up: cover property ($rose(detect));
endmodule // mrmc_cd_timer

// *** hdl/mrmc_top.sv ***
`timescale 1ns/1ns
module mrmc_top #(
    parameter logic [15:0] MS_CYCLES = 16'(mrmc_pkg::MS_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Processor bus pins
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    // Receive side
    input wire logic carrier_energy,
    input wire logic rx_qam,
    input wire mrmc_pkg::mrmc_stat_type status_in,
    // Controls to the modem core
    output mrmc_pkg::mrmc_regs_type ctrl_regs,
    output mrmc_pkg::mrmc_analog_type analog_ctrl,
    output logic carrier_detect
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        mrmc_pkg::mrmc_regs_type regs;
        logic xcvr_mode;
        logic wr_prev;
        logic [7:0] rd_data;
        logic rd_oe;
        logic [15:0] tick_cnt;
        logic tick;
        mrmc_pkg::mrmc_analog_type analog;
    } mrmc_top_state_type;

    mrmc_top_state_type st;
    mrmc_top_state_type next_st;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_pipe;
    logic rstn_sync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rstn_sync = rst_pipe[1];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    mrmc_pkg::mrmc_pins_type raw_pins;
    mrmc_pkg::mrmc_pins_type pins;

    assign raw_pins = '{
        cs_n: bus_cs_n,
        rd_n: bus_rd_n,
        wr_n: bus_wr_n,
        addr: bus_addr,
        data: bus_data_in,
        energy: carrier_energy
    };

    mrmc_sync3 #(
        .W(16),
        .IDLE(mrmc_pkg::PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .rstn(rstn_sync),
        .din(raw_pins),
        .dout(pins)
    );

    // ----------------------------------------
    // Carrier detect timing
    // ----------------------------------------
    logic cd_detect;

    mrmc_cd_timer u_cd (
        .clk(clk),
        .rstn(rstn_sync),
        .tick(st.tick),
        .energy(pins.energy),
        .qam(rx_qam),
        .detect(cd_detect)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic wr_act;
    logic rd_act;
    logic wr_edge;
    logic addr_writable;
    logic addr_readable;
    logic orig_sel;
    logic guard_sel;

    assign wr_act = !pins.cs_n && !pins.wr_n;
    assign rd_act = !pins.cs_n && !pins.rd_n;
    assign wr_edge = wr_act && !st.wr_prev;

    // Full four-bit match, so no aliasing between banks
    always_comb begin
        addr_writable = 1'b0;
        addr_readable = 1'b0;
        case (pins.addr)
            mrmc_pkg::ADDR_LINE_CTRL,
            mrmc_pkg::ADDR_CUST_CTRL,
            mrmc_pkg::ADDR_ASYNC_OPT,
            mrmc_pkg::ADDR_INTL_OPT,
            mrmc_pkg::ADDR_CLAMP_TEST,
            mrmc_pkg::ADDR_XCVR_CTRL1,
            mrmc_pkg::ADDR_XCVR_CTRL2: begin
                addr_writable = 1'b1;
            end
            mrmc_pkg::ADDR_MODEM_STAT,
            mrmc_pkg::ADDR_RELAY_STAT,
            mrmc_pkg::ADDR_XCVR_STAT: begin
                addr_readable = 1'b1;
            end
            default: begin
                addr_writable = 1'b0;
                addr_readable = 1'b0;
            end
        endcase
    end

    // Bank in use follows the last register written
    assign orig_sel = st.xcvr_mode
        ? st.regs.transceiver_control_one[mrmc_pkg::TC1_ORIG_BIT]
        : st.regs.customer_control[mrmc_pkg::CC_ORIG_BIT];
    assign guard_sel = st.xcvr_mode
        ? st.regs.transceiver_control_one[mrmc_pkg::TC1_GUARD_BIT]
        : st.regs.intl_disconnect_options[mrmc_pkg::IDO_GUARD_BIT];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.wr_prev = wr_act;
        // Millisecond enable
        next_st.tick = 1'b0;
        if (st.tick_cnt >= MS_CYCLES - 16'h0001) begin
            next_st.tick_cnt = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 16'h0001;
        end
        // Register writes, once per strobe
        if (wr_edge && addr_writable) begin
            next_st.xcvr_mode = pins.addr[mrmc_pkg::BANK_BIT];
            case (pins.addr)
                mrmc_pkg::ADDR_LINE_CTRL: begin
                    next_st.regs.line_and_phone_control = pins.data;
                end
                mrmc_pkg::ADDR_CUST_CTRL: begin
                    next_st.regs.customer_control = pins.data;
                end
                mrmc_pkg::ADDR_ASYNC_OPT: begin
                    next_st.regs.async_handshake_options = pins.data;
                end
                mrmc_pkg::ADDR_INTL_OPT: begin
                    next_st.regs.intl_disconnect_options = pins.data;
                end
                mrmc_pkg::ADDR_CLAMP_TEST: begin
                    next_st.regs.data_clamp_and_test = pins.data;
                end
                mrmc_pkg::ADDR_XCVR_CTRL1: begin
                    next_st.regs.transceiver_control_one = pins.data;
                end
                mrmc_pkg::ADDR_XCVR_CTRL2: begin
                    next_st.regs.transceiver_control_two = pins.data;
                end
                default: begin
                    next_st.regs = st.regs;
                end
            endcase
        end
        // Status reads; other addresses leave the bus undriven
        next_st.rd_oe = rd_act && addr_readable;
        next_st.rd_data = st.rd_data;
        if (rd_act) begin
            case (pins.addr)
                mrmc_pkg::ADDR_MODEM_STAT: begin
                    next_st.rd_data = status_in.modem_status;
                end
                mrmc_pkg::ADDR_RELAY_STAT: begin
                    next_st.rd_data = status_in.relay_lamp_status;
                    next_st.rd_data[mrmc_pkg::RLS_CARRIER_BIT] = cd_detect;
                end
                mrmc_pkg::ADDR_XCVR_STAT: begin
                    next_st.rd_data = status_in.transceiver_status;
                end
                default: begin
                    next_st.rd_data = st.rd_data;
                end
            endcase
        end
        // Analog selections
        next_st.analog.voice_jack = st.regs.customer_control[mrmc_pkg::CC_VOICE_BIT];
        next_st.analog.rx_high_band = orig_sel;
        next_st.analog.tx_high_band = !orig_sel;
        next_st.analog.guard_tone = guard_sel && !orig_sel;
        next_st.analog.loop_mixer = st.regs.customer_control[mrmc_pkg::CC_ALOOP_BIT];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn_sync) begin
        if (!rstn_sync) begin
            st.regs <= '{default: mrmc_pkg::REG_RESET};
            st.xcvr_mode <= 1'b0;
            st.wr_prev <= 1'b0;
            st.rd_data <= 8'h00;
            st.rd_oe <= 1'b0;
            st.tick_cnt <= 16'h0000;
            st.tick <= 1'b0;
            st.analog <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus_data_out = st.rd_data;
    assign bus_data_oe = st.rd_oe;
    assign ctrl_regs = st.regs;
    assign analog_ctrl = st.analog;
    assign carrier_detect = cd_detect;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn_sync);

    a_wr_stores_reg: assert property (wr_edge && pins.addr == mrmc_pkg::ADDR_CUST_CTRL
        |=> ctrl_regs.customer_control == $past(pins.data))
        else $error("control write lost");

    a_xcvr_write: assert property (wr_edge && pins.addr == mrmc_pkg::ADDR_XCVR_CTRL2
        |=> ctrl_regs.transceiver_control_two == $past(pins.data) && st.xcvr_mode)
        else $error("transceiver write lost");

    a_ro_wr_ignored: assert property (wr_edge && !addr_writable
        |=> $stable(st.regs) && $stable(st.xcvr_mode))
        else $error("write to non-writable address took effect");

    a_bank_track: assert property (wr_edge && addr_writable && !pins.addr[mrmc_pkg::BANK_BIT]
        |=> !st.xcvr_mode)
        else $error("modem bank not selected");

    a_no_reg_seven: assert property (rd_act && pins.addr == mrmc_pkg::ADDR_UNUSED
        |=> !bus_data_oe)
        else $error("address 7 answered");

    a_status_read: assert property (rd_act && pins.addr == mrmc_pkg::ADDR_MODEM_STAT
        |=> bus_data_oe && bus_data_out == $past(status_in.modem_status))
        else $error("status read wrong");

    a_guard_high_only: assert property (analog_ctrl.guard_tone
        |-> analog_ctrl.tx_high_band && !analog_ctrl.rx_high_band)
        else $error("guard tone in low band");

    a_rx_filter_dir: assert property (orig_sel ##1 orig_sel
        |-> analog_ctrl.rx_high_band && !analog_ctrl.tx_high_band)
        else $error("receive filter not high in originate");

    a_voice_level: assert property ($rose(ctrl_regs.customer_control[mrmc_pkg::CC_VOICE_BIT])
        |=> analog_ctrl.voice_jack)
        else $error("voice jack level not applied");

    a_loop_test: assert property ($rose(ctrl_regs.customer_control[mrmc_pkg::CC_ALOOP_BIT])
        |=> analog_ctrl.loop_mixer)
        else $error("self test loop not closed");

    a_voice_drop: assert property ($fell(ctrl_regs.customer_control[mrmc_pkg::CC_VOICE_BIT])
        |=> !analog_ctrl.voice_jack)
        else $error("data jack level not restored");

    a_loop_open: assert property ($fell(ctrl_regs.customer_control[mrmc_pkg::CC_ALOOP_BIT])
        |=> !analog_ctrl.loop_mixer)
        else $error("self test loop left closed");

    a_xcvr_bank: assert property (wr_edge && addr_writable && pins.addr[mrmc_pkg::BANK_BIT]
        |=> st.xcvr_mode)
        else $error("transceiver bank not selected");

    a_no_write_seven: assert property (wr_edge && pins.addr == mrmc_pkg::ADDR_UNUSED
        |=> $stable(ctrl_regs))
        else $error("address 7 took a write");

    a_held_strobe: assert property (wr_act && st.wr_prev
        |=> $stable(st.regs))
        else $error("held write strobe wrote twice");

    a_wo_read_quiet: assert property (rd_act && addr_writable
        |=> !bus_data_oe)
        else $error("write-only address answered");

    a_rd_data_hold: assert property (!rd_act
        |=> $stable(bus_data_out))
        else $error("read data changed without a read");

    a_relay_read: assert property (rd_act && pins.addr == mrmc_pkg::ADDR_RELAY_STAT
        |=> bus_data_oe && bus_data_out[mrmc_pkg::RLS_CARRIER_BIT] == $past(cd_detect))
        else $error("carrier bit read wrong");

    a_xcvr_stat_read: assert property (rd_act && pins.addr == mrmc_pkg::ADDR_XCVR_STAT
        |=> bus_data_oe && bus_data_out == $past(status_in.transceiver_status))
        else $error("transceiver status read wrong");

    a_orig_rx_high: assert property (wr_edge && pins.addr == mrmc_pkg::ADDR_CUST_CTRL
        && pins.data[mrmc_pkg::CC_ORIG_BIT] |=> ##1 analog_ctrl.rx_high_band && !analog_ctrl.tx_high_band)
        else $error("originate did not pick high band receive");

    a_answer_rx_low: assert property (wr_edge && pins.addr == mrmc_pkg::ADDR_XCVR_CTRL1
        && !pins.data[mrmc_pkg::TC1_ORIG_BIT] |=> ##1 !analog_ctrl.rx_high_band && analog_ctrl.tx_high_band)
        else $error("answer did not pick low band receive");

    a_tick_single: assert property (st.tick
        |=> !st.tick)
        else $error("millisecond enable wider than one cycle");

    c_xcvr_bank: cover property (wr_edge && pins.addr == mrmc_pkg::ADDR_XCVR_CTRL1);
    c_status_rd: cover property (rd_act && pins.addr == mrmc_pkg::ADDR_RELAY_STAT ##1 bus_data_oe);
    c_guard_on: cover property ($rose(analog_ctrl.guard_tone));
    c_carrier: cover property ($rose(carrier_detect));
endmodule // mrmc_top

// *** tb/mrmc_host_model.sv ***
`timescale 1ns/1ns
module mrmc_host_model (
    // Clock
    input wire logic clk,
    // Bus pins driven by the host
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    // Read side of the device
    input wire logic [7:0] rdata,
    input wire logic rdata_oe
);
    // ----------------------------------------
    // Strobe timing
    // ----------------------------------------
    // Strobes low and high for longer than the synchroniser needs
    localparam int unsigned HOLD = 6;

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        repeat (HOLD) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (HOLD) @(posedge clk);
        // Released data lines no longer show the byte
        wdata <= ~d;
    endtask

    task automatic read_reg(input logic [3:0] a, output logic oe, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (HOLD) @(posedge clk);
        oe = rdata_oe;
        d = rdata;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (HOLD) @(posedge clk);
    endtask
endmodule // mrmc_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    localparam logic [15:0] MS = 16'h0014;
    localparam int MS_N = 20;
    localparam int TIMEOUT = 20000;
    typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic [55:0] exp_regs;} mrmc_tb_row_type;
    typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic [4:0] exp_ana;} mrmc_tb_ana_type;
    localparam mrmc_tb_row_type ROWS [12] = '{
        '{4'h0, 8'hA5, 56'hA5000000000000}, '{4'h1, 8'h3C, 56'hA53C0000000000},
        '{4'h4, 8'h5A, 56'hA53C5A00000000}, '{4'h5, 8'hC3, 56'hA53C5AC3000000},
        '{4'h6, 8'h96, 56'hA53C5AC3960000}, '{4'h8, 8'h69, 56'hA53C5AC3966900},
        '{4'h9, 8'hF0, 56'hA53C5AC39669F0}, '{4'h2, 8'hFF, 56'hA53C5AC39669F0},
        '{4'h3, 8'hFF, 56'hA53C5AC39669F0}, '{4'h7, 8'hFF, 56'hA53C5AC39669F0},
        '{4'hA, 8'hFF, 56'hA53C5AC39669F0}, '{4'hB, 8'hFF, 56'hA53C5AC39669F0}};
    localparam mrmc_tb_ana_type ANA [6] = '{
        '{4'h8, 8'h69, 5'h15}, '{4'h8, 8'h01, 5'h1B}, '{4'h1, 8'h00, 5'h08},
        '{4'h5, 8'h20, 5'h0A}, '{4'h1, 8'h10, 5'h04}, '{4'h1, 8'h24, 5'h1B}};

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_cs_n;
    logic bus_rd_n;
    logic bus_wr_n;
    logic [3:0] bus_addr;
    logic [7:0] bus_data_in;
    logic [7:0] bus_data_out;
    logic bus_data_oe;
    logic carrier_energy = 1'b0;
    logic rx_qam = 1'b0;
    mrmc_pkg::mrmc_stat_type status_in = 24'h5AA5C3;
    mrmc_pkg::mrmc_regs_type ctrl_regs;
    mrmc_pkg::mrmc_analog_type analog_ctrl;
    logic carrier_detect;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycle_cnt = 0;

    always #25 clk = ~clk;

    mrmc_top #(.MS_CYCLES(MS)) mrmc_top_inst (
        .clk(clk), .rstn(rstn), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .carrier_energy(carrier_energy), .rx_qam(rx_qam),
        .status_in(status_in), .ctrl_regs(ctrl_regs), .analog_ctrl(analog_ctrl),
        .carrier_detect(carrier_detect));

    mrmc_host_model mrmc_host_model_inst (
        .clk(clk), .cs_n(bus_cs_n), .rd_n(bus_rd_n), .wr_n(bus_wr_n), .addr(bus_addr),
        .wdata(bus_data_in), .rdata(bus_data_out), .rdata_oe(bus_data_oe));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // Time from an energy change to the detect change, in a window of ms
    task automatic carrier_edge(input logic lvl, input logic qam, input int lo, input int hi, input string name);
        int n;
        n = 0;
        @(posedge clk);
        rx_qam <= qam;
        carrier_energy <= lvl;
        while (carrier_detect !== lvl && n < (hi + 5) * MS_N) begin
            @(posedge clk);
            n++;
        end
        check(name, 64'(n >= lo * MS_N && n <= hi * MS_N), 64'h1);
    endtask

    always @(posedge clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == TIMEOUT) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic oe;
        logic [7:0] d;
        logic exp_oe;
        logic [7:0] exp_d;
        do_reset();
        check("reset_ctrl", 64'(ctrl_regs), 64'h0);
        check("reset_analog", 64'(analog_ctrl), 64'h08);
        check("reset_oe", 64'(bus_data_oe), 64'h0);
        check("reset_cd", 64'(carrier_detect), 64'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            mrmc_host_model_inst.write_reg(ROWS[i].addr, ROWS[i].wdata);
            check("ctrl_regs", 64'(ctrl_regs), 64'(ROWS[i].exp_regs));
        end
        $display("test register writes done");
        for (int i = 0; i < 6; i++) begin
            mrmc_host_model_inst.write_reg(ANA[i].addr, ANA[i].wdata);
            check("analog_ctrl", 64'(analog_ctrl), 64'(ANA[i].exp_ana));
        end
        $display("test analog selects done");
        carrier_edge(1'b1, 1'b0, 40, 205, "cd_acquire");
        for (int a = 0; a < 16; a++) begin
            exp_oe = (a == 2 || a == 3 || a == 10);
            exp_d = (a == 2) ? 8'h5A : (a == 3) ? 8'hAD : 8'hC3;
            mrmc_host_model_inst.read_reg(4'(a), oe, d);
            check("read_oe", 64'(oe), 64'(exp_oe));
            if (exp_oe) begin
                check("read_data", 64'(d), 64'(exp_d));
            end
        end
        $display("test register reads done");
        carrier_edge(1'b0, 1'b0, 10, 24, "cd_release_psk");
        carrier_edge(1'b1, 1'b1, 40, 205, "cd_acquire_qam");
        carrier_edge(1'b0, 1'b1, 40, 65, "cd_release_qam");
        $display("test carrier detect done");
        do_reset();
        check("rereset_ctrl", 64'(ctrl_regs), 64'h0);
        check("rereset_analog", 64'(analog_ctrl), 64'h08);
        $display("test second reset done");
        end_of_test();
    end
endmodule // tb_top
